// ### hdl/sts_pkg.sv
// sts_pkg: constants and types for the target command sequencer
// assumes: 200 MHz system clock, bus pins arrive asynchronous
package sts_pkg;
   localparam int          CLK_MHZ        = 200;
   localparam int          BSY_RESP_US    = 250;
   localparam int          BSY_RESP_CYC   = BSY_RESP_US * CLK_MHZ;
   localparam int          DESKEW_NS      = 45;
   localparam int          DESKEW_CYC     = (DESKEW_NS * CLK_MHZ + 999) / 1000;
   localparam int          SETTLE_CYC     = 2 * DESKEW_CYC;
   localparam int          NUM_LUN        = 4;
   localparam int          NUM_PORT       = 8;
   // opcodes
   localparam logic [7:0]  OP_SENSE       = 8'h03;
   localparam logic [7:0]  OP_FORMAT      = 8'h04;
   localparam logic [7:0]  OP_PARAM       = 8'h15;
   // command byte positions
   localparam logic [3:0]  CDB6_LEN       = 4'h6;
   localparam logic [3:0]  CDB10_LEN      = 4'hA;
   localparam logic [3:0]  PARAM_CNT_POS  = 4'h4;
   localparam logic [3:0]  FMT_FLAG_POS   = 4'h1;
   localparam logic [3:0]  FMT_FILL_POS   = 4'h2;
   localparam logic [3:0]  FMT_ILV_HI_POS = 4'h3;
   localparam logic [3:0]  FMT_ILV_LO_POS = 4'h4;
   localparam int          FMT_FILL_BIT   = 4;
   localparam int          FMT_DEFL_BIT   = 3;
   localparam int          LUN_LSB        = 5;
   // parameter list layout (offset from start of appended data)
   localparam logic [7:0]  HDR_LEN        = 8'h04;
   localparam logic [7:0]  DESC_LEN       = 8'h08;
   localparam logic [7:0]  PL_DESC_LEN    = 8'h03;
   localparam logic [7:0]  PL_DENSITY     = 8'h04;
   localparam logic [7:0]  PL_BS_HI       = 8'h09;
   localparam logic [7:0]  PL_BS_MID      = 8'h0A;
   localparam logic [7:0]  PL_BS_LO       = 8'h0B;
   localparam logic [7:0]  PL_IFCODE      = 8'h0C;
   localparam logic [7:0]  PL_CYL_HI      = 8'h0D;
   localparam logic [7:0]  PL_CYL_LO      = 8'h0E;
   localparam logic [7:0]  PL_HEADS       = 8'h0F;
   localparam logic [7:0]  PL_RWC_HI      = 8'h10;
   localparam logic [7:0]  PL_RWC_LO      = 8'h11;
   localparam logic [7:0]  PL_PRE_HI      = 8'h12;
   localparam logic [7:0]  PL_PRE_LO      = 8'h13;
   localparam logic [7:0]  PL_LAND        = 8'h14;
   localparam logic [7:0]  PL_STEP        = 8'h15;
   localparam logic [7:0]  PL_STD_LEN     = 8'h16;
   localparam logic [7:0]  PL_HS_EXTRA    = 8'h02;
   localparam logic [7:0]  IFCODE_OK      = 8'h01;
   // format data block layout
   localparam logic [7:0]  FD_SCOPE       = 8'h00;
   localparam logic [7:0]  FD_SPARE       = 8'h01;
   localparam logic [7:0]  FD_DLEN_HI     = 8'h02;
   localparam logic [7:0]  FD_DLEN_LO     = 8'h03;
   localparam logic [7:0]  FD_HDR_LEN     = 8'h04;
   localparam logic [7:0]  DEFECT_LEN     = 8'h08;
   // sectors per track
   localparam logic [5:0]  SPT_256_I1     = 6'd32;
   localparam logic [5:0]  SPT_256_IN     = 6'd33;
   localparam logic [5:0]  SPT_512_I1     = 6'd17;
   localparam logic [5:0]  SPT_512_IN     = 6'd18;
   localparam logic [5:0]  SPT_1K         = 6'd9;
   // status and message bytes
   localparam logic [7:0]  ST_GOOD        = 8'h00;
   localparam logic [7:0]  ST_CHECK       = 8'h02;
   localparam logic [7:0]  ST_BUSY        = 8'h08;
   localparam logic [7:0]  MSG_COMPLETE   = 8'h00;
   // phase codes {msg, cd, io}
   localparam logic [2:0]  PH_DOUT        = 3'h0;
   localparam logic [2:0]  PH_DIN         = 3'h1;
   localparam logic [2:0]  PH_CMD         = 3'h2;
   localparam logic [2:0]  PH_STAT        = 3'h3;
   localparam logic [2:0]  PH_MIN         = 3'h7;
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0, S_SEL   = 4'h1, S_CMD   = 4'h3, S_DOUT  = 4'h2,
      S_DIN   = 4'h6, S_STAT  = 4'h7, S_MSG   = 4'h5, S_FREE  = 4'h4
   } sts_state_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'h0, H_REQ = 2'h1, H_WAIT = 2'h3
   } sts_hs_t;
endpackage

// ### hdl/sts_link_if.sv
// sts_link_if: byte handshake between sequencer core and REQ/ACK engine
// assumes: both ends on clk_i
`timescale 1ns/1ps
`default_nettype none
interface sts_link_if;
   logic       start;
   logic       to_init;
   logic [7:0] tx_data;
   logic       done;
   logic [7:0] rx_data;
   logic       rx_perr;
   modport core (output start, output to_init, output tx_data,
                 input done, input rx_data, input rx_perr);
   modport hs   (input start, input to_init, input tx_data,
                 output done, output rx_data, output rx_perr);
endinterface
`default_nettype wire

// ### hdl/sts_handshake.sv
// sts_handshake: one REQ/ACK byte transfer per start pulse
// assumes: ack and data inputs already synchronised by the caller
`timescale 1ns/1ps
`default_nettype none
module sts_handshake
   import sts_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  resetn_i,
   input  wire logic  ack_i,
   input  wire logic  [7:0] db_i,
   input  wire logic  dbp_i,
   output logic       req_o,
   output logic       [7:0] db_o,
   output logic       dbp_o,
   output logic       db_oe_n_o,
   sts_link_if.hs     lnk
);
   typedef struct packed {
      sts_hs_t    st;
      logic       req;
      logic [7:0] db;
      logic       dbp;
      logic       oe_n;
      logic       done;
      logic [7:0] rx;
      logic       perr;
      logic [4:0] cnt;
   } sts_hs_reg_t;
   sts_hs_reg_t r, n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      unique case (r.st)
         H_IDLE: begin
            if (lnk.start) begin
               n.oe_n = ~lnk.to_init;
               n.db   = lnk.tx_data;
               n.dbp  = ~^lnk.tx_data;
               n.cnt  = 5'(SETTLE_CYC);
               n.st   = H_REQ;
            end
         end
         H_REQ: begin
            if (r.cnt != 5'h00) begin
               n.cnt = r.cnt - 5'h01;
            end else if (!r.req) begin
               n.req = 1'b1;
            end else if (ack_i) begin
               n.rx   = db_i;
               n.perr = ~(^{db_i, dbp_i});
               n.req  = 1'b0;
               n.st   = H_WAIT;
            end
         end
         H_WAIT: begin
            if (!ack_i) begin
               n.oe_n = 1'b1;
               n.done = 1'b1;
               n.st   = H_IDLE;
            end
         end
         default: n.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '{st: H_IDLE, req: 1'b0, db: 8'h00, dbp: 1'b0, oe_n: 1'b1,
                done: 1'b0, rx: 8'h00, perr: 1'b0, cnt: 5'h00};
      end else begin
         r <= n;
      end
   end

   assign req_o       = r.req;
   assign db_o        = r.db;
   assign dbp_o       = r.dbp;
   assign db_oe_n_o   = r.oe_n;
   assign lnk.done    = r.done;
   assign lnk.rx_data = r.rx;
   assign lnk.rx_perr = r.perr;
endmodule
`default_nettype wire

// ### hdl/sts_sequencer.sv
// sts_sequencer: target-only command sequencer on the parallel disk bus
// assumes: bus pins asynchronous to clk_i; jumpers static after reset
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer
   import sts_pkg::*;
#(
   parameter int BSY_TIMEOUT = BSY_RESP_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [2:0]  own_id_i,
   input  wire logic        par_en_i,
   input  wire logic [1:0]  hard_sect_i,
   input  wire logic        sel_i,
   input  wire logic        bsy_i,
   input  wire logic        io_i,
   input  wire logic        ack_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  db_i,
   input  wire logic        dbp_i,
   input  wire logic        xfer_ok_i,
   output logic             bsy_o,
   output logic             bsy_oe_n_o,
   output logic             req_o,
   output logic             cd_o,
   output logic             io_o,
   output logic             msg_o,
   output logic [7:0]       db_o,
   output logic             dbp_o,
   output logic             db_oe_n_o,
   output logic             busy_o,
   output logic [7:0]       last_op_o,
   output logic [1:0]       lun_o,
   output logic [3:0]       lun_fmt_ok_o,
   output logic [15:0]      cyl_cnt_o,
   output logic [7:0]       heads_o,
   output logic [23:0]      blk_size_o,
   output logic [15:0]      ilv_o,
   output logic [7:0]       fill_o,
   output logic [7:0]       spares_o,
   output logic [5:0]       spt_o,
   output logic [15:0]      defect_cnt_o,
   output logic [7:0]       status_o
);
   if (BSY_TIMEOUT < 1) begin : g_bad_timeout
      $error("BSY_TIMEOUT must be positive");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 14;
   logic [SW-1:0] s1_r, s2_r;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= {sel_i, bsy_i, io_i, ack_i, rst_i, dbp_i, db_i};
         s2_r <= s1_r;
      end
   end
   logic       sel_s, bsy_s, io_s, ack_s, rst_s, dbp_s;
   logic [7:0] db_s;
   assign {sel_s, bsy_s, io_s, ack_s, rst_s, dbp_s, db_s} = s2_r;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] cdb_len(input logic [7:0] op);
      cdb_len = (op[7:5] == 3'h0) ? CDB6_LEN : CDB10_LEN;
   endfunction

   function automatic logic [5:0] sec_per_trk(input logic [23:0] bs,
                                              input logic [15:0] ilv);
      logic one;
      one = (ilv <= 16'h0001);
      sec_per_trk = SPT_1K;
      if (bs[15:8] == 8'h01) sec_per_trk = one ? SPT_256_I1 : SPT_256_IN;
      else if (bs[15:8] == 8'h02)
         sec_per_trk = one ? SPT_512_I1 : SPT_512_IN;
   endfunction

   sts_link_if lnk ();

   sts_handshake u_hs (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .ack_i     (ack_s),
      .db_i      (db_s),
      .dbp_i     (dbp_s),
      .req_o     (req_o),
      .db_o      (db_o),
      .dbp_o     (dbp_o),
      .db_oe_n_o (db_oe_n_o),
      .lnk       (lnk.hs)
   );

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   typedef struct packed {
      sts_state_t  st;
      logic        bsy;
      logic [2:0]  ph;
      logic        start;
      logic        wait_d;
      logic [7:0]  txd;
      logic [3:0]  idx;
      logic [3:0]  clen;
      logic [7:0]  op;
      logic [1:0]  lun;
      logic [7:0]  dcnt;
      logic [15:0] dlen;
      logic [15:0] dpos;
      logic        perr;
      logic        bad;
      logic [7:0]  stat;
      logic [3:0]  fmt_ok;
      logic [3:0]  par_ok;
      logic [15:0] cyl;
      logic [7:0]  heads;
      logic [23:0] bs;
      logic [15:0] ilv;
      logic [7:0]  fill;
      logic        fill_en;
      logic        defl_en;
      logic [7:0]  spares;
      logic [5:0]  spt;
      logic [15:0] defects;
      logic [7:0]  dbyte_hi;
      logic [7:0]  dbyte_lo;
      logic [7:0]  hdr3;
   } sts_reg_t;
   sts_reg_t r, n;

   logic [7:0] rx;
   assign rx = lnk.rx_data;

   always_comb begin
      n = r;
      n.start = 1'b0;
      unique case (r.st)
         S_IDLE: begin
            // only selection is answered, never arbitration for own use
            if (sel_s && !bsy_s && !io_s && db_s[own_id_i] && !rst_s &&
                !(par_en_i && !(^{db_s, dbp_s}))) begin
               n.bsy = 1'b1;
               n.st  = S_SEL;
            end
         end
         S_SEL: begin
            if (!sel_s) begin
               n.ph   = PH_CMD;
               n.idx  = 4'h0;
               n.clen = CDB6_LEN;
               n.perr = 1'b0;
               n.bad  = 1'b0;
               n.start = 1'b1;
               n.wait_d = 1'b1;
               n.stat = 8'h00;
               n.st   = S_CMD;
            end
         end
         S_CMD: begin
            if (lnk.done) begin
               n.perr = r.perr | (par_en_i & lnk.rx_perr);
               if (r.idx == 4'h0) begin
                  n.op   = rx;
                  n.clen = cdb_len(rx);
               end
               if (r.idx == FMT_FLAG_POS) begin
                  n.lun = rx[LUN_LSB +: 2];
                  if (r.op == OP_FORMAT) begin
                     n.fill_en = rx[FMT_FILL_BIT];
                     n.defl_en = rx[FMT_DEFL_BIT];
                  end
               end
               if (r.op == OP_FORMAT && r.idx == FMT_FILL_POS) n.fill = rx;
               if (r.op == OP_FORMAT && r.idx == FMT_ILV_HI_POS) begin
                  n.ilv[15:8] = rx;
                  n.bad = r.bad | (rx != 8'h00);
               end
               if (r.op == OP_FORMAT && r.idx == FMT_ILV_LO_POS)
                  n.ilv[7:0] = rx;
               if (r.op == OP_PARAM && r.idx == PARAM_CNT_POS)
                  n.dcnt = rx;
               n.idx = r.idx + 4'h1;
               if (r.idx + 4'h1 == n.clen) begin
                  n.dpos = 16'h0000;
                  n.dlen = 16'h0000;
                  if (r.op == OP_PARAM && n.dcnt != 8'h00) begin
                     n.dlen = {8'h00, n.dcnt};
                     n.st   = S_DOUT;
                  end else if (r.op == OP_FORMAT && (n.fill_en|n.defl_en))
                  begin
                     n.dlen = {8'h00, FD_HDR_LEN};
                     n.st   = S_DOUT;
                  end else begin
                     n.st = S_STAT;
                  end
                  n.ph = (n.st == S_DOUT) ? PH_DOUT : PH_STAT;
               end
               // status waits a cycle so its checks settle first
               n.start = (n.st != S_STAT);
            end
         end
         S_DOUT: begin
            if (lnk.done) begin
               n.perr = r.perr | (par_en_i & lnk.rx_perr);
               if (r.op == OP_PARAM) begin
                  unique case (r.dpos[7:0])
                     PL_DESC_LEN: begin
                        n.hdr3 = rx;
                        n.bad  = r.bad | (rx != DESC_LEN);
                     end
                     PL_BS_HI:  n.bs[23:16] = rx;
                     PL_BS_MID: n.bs[15:8]  = rx;
                     PL_BS_LO:  n.bs[7:0]   = rx;
                     PL_IFCODE: n.bad = r.bad | (rx != IFCODE_OK);
                     PL_CYL_HI: n.cyl[15:8] = rx;
                     PL_CYL_LO: n.cyl[7:0]  = rx;
                     PL_HEADS:  n.heads     = rx;
                     default: ;
                  endcase
               end else begin
                  unique case (r.dpos[7:0])
                     FD_SPARE:   n.spares = rx;
                     FD_DLEN_HI: n.dbyte_hi = rx;
                     FD_DLEN_LO: begin
                        n.dbyte_lo = rx;
                        n.dlen = 16'({FD_HDR_LEN} + {r.dbyte_hi, rx});
                        n.defects = 16'({r.dbyte_hi, rx} >> 3);
                     end
                     default: ;
                  endcase
               end
               n.dpos = r.dpos + 16'h0001;
               if (r.dpos + 16'h0001 >= n.dlen) begin
                  n.ph = PH_STAT;
                  n.st = S_STAT;
               end
               n.start = (n.st != S_STAT);
            end
         end
         S_STAT: begin
            if (r.wait_d) begin
               n.wait_d = 1'b0;
               if (r.op == OP_PARAM) begin
                  // short list or hard-sectored list without extra bytes
                  if (r.dlen < 16'(PL_STD_LEN) ||
                      (r.lun[1] == 1'b0 && hard_sect_i[r.lun[0]] &&
                       r.dlen < 16'(PL_STD_LEN + PL_HS_EXTRA)))
                     n.bad = 1'b1;
               end
               if (r.op == OP_FORMAT) begin
                  if (!r.par_ok[r.lun]) n.bad = 1'b1;
                  if (r.ilv >= {10'h000, sec_per_trk(r.bs, r.ilv)})
                     n.bad = 1'b1;
               end
            end else if (r.stat != 8'hFF) begin
               n.txd   = (!xfer_ok_i) ? ST_BUSY :
                         (r.bad || r.perr) ? ST_CHECK : ST_GOOD;
               n.start = 1'b1;
               n.stat  = 8'hFF;
            end
            if (lnk.done) begin
               n.ph    = PH_MIN;
               n.txd   = MSG_COMPLETE;
               n.start = 1'b1;
               n.st    = S_MSG;
               if (!r.bad && !r.perr && xfer_ok_i) begin
                  if (r.op == OP_PARAM) begin
                     n.par_ok[r.lun] = 1'b1;
                     n.fmt_ok[r.lun] = 1'b0;
                  end
                  if (r.op == OP_FORMAT) begin
                     n.fmt_ok[r.lun] = 1'b1;
                     n.spt = sec_per_trk(r.bs, r.ilv);
                  end
               end
            end
         end
         S_MSG: begin
            if (lnk.done) begin
               n.st  = S_FREE;
               n.bsy = 1'b0;
            end
         end
         S_FREE: begin
            n.ph   = PH_DOUT;
            n.txd  = 8'h00;
            n.stat = 8'h00;
            n.wait_d = 1'b1;
            n.st   = S_IDLE;
         end
         default: n.st = S_IDLE;
      endcase
      if (rst_s) begin
         n.st  = S_IDLE;
         n.bsy = 1'b0;
         n.ph  = PH_DOUT;
         n.start = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '0;
         r.st <= S_IDLE;
         r.wait_d <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // status word sent is the computed byte kept aside from the marker
   logic [7:0] stat_byte_r;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_byte_r <= ST_GOOD;
      end else if (r.st == S_STAT && n.stat == 8'hFF && r.stat != 8'hFF) begin
         stat_byte_r <= (!xfer_ok_i) ? ST_BUSY :
                        (r.bad || r.perr) ? ST_CHECK : ST_GOOD;
      end
   end

   assign lnk.start   = r.start;
   assign lnk.to_init = r.ph[0];
   assign lnk.tx_data = r.txd;

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign bsy_o        = r.bsy;
   assign bsy_oe_n_o   = ~r.bsy;
   assign msg_o        = r.ph[2];
   assign cd_o         = r.ph[1];
   assign io_o         = r.ph[0];
   assign busy_o       = r.bsy;
   assign last_op_o    = r.op;
   assign lun_o        = r.lun;
   assign lun_fmt_ok_o = r.fmt_ok;
   assign cyl_cnt_o    = r.cyl;
   assign heads_o      = r.heads;
   assign blk_size_o   = r.bs;
   assign ilv_o        = r.ilv;
   assign fill_o       = r.fill;
   assign spares_o     = r.spares;
   assign spt_o        = r.spt;
   assign defect_cnt_o = r.defects;
   assign status_o     = stat_byte_r;
endmodule
`default_nettype wire

// ### sim/sts_checker.sv
// sts_checker: bus-side properties of the target sequencer
// assumes: bound to sts_sequencer, single clock domain
`timescale 1ns/1ps
`default_nettype none
module sts_checker
   import sts_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       sel_i,
   input wire logic       io_i,
   input wire logic       ack_i,
   input wire logic       bsy_o,
   input wire logic       bsy_oe_n_o,
   input wire logic       req_o,
   input wire logic       cd_o,
   input wire logic       io_o,
   input wire logic       msg_o,
   input wire logic [7:0] db_o,
   input wire logic       dbp_o,
   input wire logic       db_oe_n_o,
   input wire logic [7:0] last_op_o,
   input wire logic [7:0] status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [2:0] ph;
   logic       req_d_r;
   logic [3:0] ncmd_r;
   logic [3:0] ncmd_nxt;
   assign ph = {msg_o, cd_o, io_o};
   // command bytes requested since BSY came up
   always_comb ncmd_nxt = !bsy_o ? 4'h0
      : ncmd_r + {3'h0, req_o & ~req_d_r & (ph == PH_CMD)};
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_d_r <= 1'b0;
         ncmd_r  <= 4'h0;
      end else begin
         req_d_r <= req_o;
         ncmd_r  <= ncmd_nxt;
      end
   end
   sequence s_stat; $rose(req_o) && ph == PH_STAT; endsequence
   sequence s_msg; $rose(req_o) && ph == PH_MIN; endsequence
   property p_own; req_o |-> bsy_o && !bsy_oe_n_o; endproperty
   a_own: assert property (p_own) else $error("req off bus");
   property p_dir; !db_oe_n_o |-> io_o; endproperty
   a_dir: assert property (p_dir) else $error("bad drive");
   property p_par; req_o && io_o |-> !db_oe_n_o && ^{db_o, dbp_o}; endproperty
   a_par: assert property (p_par) else $error("bad parity");
   property p_hold; req_o && !ack_i && !$past(ack_i) |=> req_o; endproperty
   a_hold: assert property (p_hold) else $error("req dropped");
   property p_stat; s_stat |-> db_o == status_o ##[1:400] s_msg; endproperty
   a_stat: assert property (p_stat) else $error("no message");
   property p_msg; s_msg |-> db_o == MSG_COMPLETE ##[1:400] !bsy_o;
   endproperty
   a_msg: assert property (p_msg) else $error("bad message");
   property p_len;
      s_stat |-> ncmd_r == (last_op_o[7:5] == 3'h0 ? CDB6_LEN : CDB10_LEN);
   endproperty
   a_len: assert property (p_len) else $error("bad cmd length");
   property p_sel; $rose(bsy_o) |-> sel_i && !io_i; endproperty
   a_sel: assert property (p_sel) else $error("bsy unselected");
endmodule
bind sts_sequencer sts_checker u_sts_checker (.clk_i(clk_i),
   .resetn_i(resetn_i), .sel_i(sel_i), .io_i(io_i), .ack_i(ack_i),
   .bsy_o(bsy_o), .bsy_oe_n_o(bsy_oe_n_o), .req_o(req_o), .cd_o(cd_o),
   .io_o(io_o), .msg_o(msg_o), .db_o(db_o), .dbp_o(dbp_o),
   .db_oe_n_o(db_oe_n_o), .last_op_o(last_op_o), .status_o(status_o));
`default_nettype wire

// ### sim/sts_init_model.sv
// sts_init_model: behavioural initiator on the bus
// assumes: bench resolves the data wire, bytes queued in tx_q
`timescale 1ns/1ps
`default_nettype none
module sts_init_model
   import sts_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic       bsy_i,
   input  wire logic [2:0] ph_i,
   input  wire logic [7:0] db_i,
   output logic            sel_o,
   output logic            ack_o,
   output logic [7:0]      db_o,
   output logic            dbp_o
);
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   int         n_ph[8];
   int         slow = 0;
   initial begin
      {sel_o, ack_o, db_o, dbp_o} = 11'h001;
   end
   task automatic put(input logic [7:0] b);
      db_o  <= b;
      dbp_o <= ~^b;
   endtask
   task automatic run(input logic [2:0] id);
      int t;
      rx_q = {};
      n_ph = '{default:0};
      put(8'h01 << id);
      sel_o <= 1'b1;
      for (t = 0; !bsy_i && t < 100; t++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      sel_o <= 1'b0;
      put(~db_o);
      for (t = 0; bsy_i && t < 5000; t++) begin
         @(posedge clk_i);
         if (req_i && !ack_o) begin
            repeat (slow) @(posedge clk_i);
            n_ph[ph_i]++;
            if (ph_i[0]) rx_q.push_back(db_i);
            else put(tx_q.size() ? tx_q.pop_front() : 8'h00);
            @(posedge clk_i);
            ack_o <= 1'b1;
            while (req_i) @(posedge clk_i);
            ack_o <= 1'b0;
            put(~db_o);
         end
      end
   endtask
endmodule
`default_nettype wire

// ### sim/test_scsi_target_command_sequencer.sv
// test_scsi_target_command_sequencer: random and corner commands
// assumes: initiator model answers every REQ
`timescale 1ns/1ps
`default_nettype none
module test_scsi_target_command_sequencer;
   import sts_pkg::*;
   logic        clk_i, resetn_i, par_en_i, xfer_ok_i, sel, ack, m_dbp;
   logic        bsy_o, bsy_oe_n_o, req_o, cd_o, io_o, msg_o, dbp_o, db_oe_n_o;
   logic [2:0]  own_id_i;
   logic [1:0]  hard_sect_i, lun_o;
   logic [7:0]  m_db, db_o, heads_o, fill_o, spares_o, status_o, last_op_o;
   logic [3:0]  lun_fmt_ok_o;
   logic [5:0]  spt_o;
   logic [15:0] cyl_cnt_o, ilv_o, defect_cnt_o;
   logic [23:0] blk_size_o;
   int          n_errors = 0;
   int          n_tests = 0;
   logic [7:0]  z = 8'h00;
   sts_sequencer #(.BSY_TIMEOUT(10)) u_sts_sequencer (.clk_i(clk_i),
      .resetn_i(resetn_i), .own_id_i(own_id_i), .par_en_i(par_en_i),
      .hard_sect_i(hard_sect_i), .sel_i(sel), .bsy_i(bsy_o), .io_i(1'b0),
      .ack_i(ack), .rst_i(1'b0), .db_i(db_oe_n_o ? m_db : db_o),
      .dbp_i(db_oe_n_o ? m_dbp : dbp_o), .xfer_ok_i(xfer_ok_i),
      .bsy_o(bsy_o), .bsy_oe_n_o(bsy_oe_n_o), .req_o(req_o), .cd_o(cd_o),
      .io_o(io_o), .msg_o(msg_o), .db_o(db_o), .dbp_o(dbp_o),
      .db_oe_n_o(db_oe_n_o), .busy_o(), .last_op_o(last_op_o), .lun_o(lun_o),
      .lun_fmt_ok_o(lun_fmt_ok_o), .cyl_cnt_o(cyl_cnt_o), .heads_o(heads_o),
      .blk_size_o(blk_size_o), .ilv_o(ilv_o), .fill_o(fill_o),
      .spares_o(spares_o), .spt_o(spt_o), .defect_cnt_o(defect_cnt_o),
      .status_o(status_o));
   sts_init_model u_sts_init_model (.clk_i(clk_i), .req_i(req_o),
      .bsy_i(bsy_o & ~bsy_oe_n_o), .ph_i({msg_o, cd_o, io_o}),
      .db_i(db_oe_n_o ? m_db : db_o), .sel_o(sel), .ack_o(ack),
      .db_o(m_db), .dbp_o(m_dbp));
   // ---
   // checking and command helpers
   // ---
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic int clen(input logic [7:0] op);
      return op[7:5] == 3'h0 ? 6 : 10;
   endfunction
   task automatic cmd(input logic [7:0] b[$], input int nd,
                      input logic [7:0] st);
      u_sts_init_model.tx_q = b;
      u_sts_init_model.run(own_id_i);
      chk(u_sts_init_model.n_ph[PH_CMD], clen(b[0]));
      chk(u_sts_init_model.n_ph[PH_DOUT], nd);
      chk(u_sts_init_model.rx_q.size(), 2);
      chk(u_sts_init_model.rx_q[0], st);
      chk(u_sts_init_model.rx_q[1], MSG_COMPLETE);
      $display("cmd %h done", b[0]);
   endtask
   task automatic test_done;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      n_errors++;
      test_done;
   end
   initial begin
      logic [7:0]  p[$];
      logic [15:0] r;
      void'($urandom(32'h633B));
      {resetn_i, par_en_i, xfer_ok_i, own_id_i, hard_sect_i} = 8'h74;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 3; i++) begin
         r = $urandom;
         u_sts_init_model.slow = i;
         p = {OP_PARAM, z, z, z, PL_STD_LEN, z, z, z, z, DESC_LEN, z, z, z,
              z, z, z, 8'h01, z, i ? IFCODE_OK : 8'h02, r[15:8], r[7:0],
              r[7:0], 8'h01, z, 8'h01, z, z, 8'h01};
         cmd(p, 22, i ? ST_GOOD : ST_CHECK);
         if (i) chk(cyl_cnt_o, r);
         if (i) chk(heads_o, r[7:0]);
         if (i) chk(blk_size_o, 24'h000100);
      end
      for (int i = 0; i < 2; i++) begin
         r = i ? 16'd2 + 16'($urandom % 30) : 16'd1;
         p = {OP_FORMAT, 8'h18, 8'hE5, r[15:8], r[7:0], z, z, 8'h02, z,
              8'h08, z, z, 8'h0B, 8'h02, z, z, 8'h01, z};
         cmd(p, 12, ST_GOOD);
         chk(ilv_o, r);
         chk(spt_o, i ? SPT_256_IN : SPT_256_I1);
         chk({fill_o, spares_o}, 16'hE502);
         chk(defect_cnt_o, 16'h0001);
      end
      p = {OP_FORMAT, 8'h40, z, z, 8'h01, z};
      cmd(p, 0, ST_CHECK);
      chk(lun_fmt_ok_o, 4'h1);
      chk(lun_o, 2'h2);
      p = {OP_SENSE, z, z, z, z, z};
      cmd(p, 0, ST_GOOD);
      xfer_ok_i <= 1'b0;
      p = {8'h25, z, z, z, z, z, z, z, z, z};
      cmd(p, 0, ST_BUSY);
      xfer_ok_i <= 1'b1;
      cmd(p, 0, ST_GOOD);
      test_done;
   end
endmodule
`default_nettype wire
